// ---- rxfb_pkg.sv ----
// Package for the receive buffer flag bank: register map, widths, reset values.
// Assumes a plain address/strobe register port with 16-bit registers.
package rxfb_pkg;

   localparam int unsigned ADDR_W       = 4;
   localparam int unsigned REG_W        = 16;
   localparam int unsigned NUM_BUF      = 32;
   localparam int unsigned IRQ_W        = 2;

   // Register indices on the plain port
   localparam logic [3:0] ADDR_FULL_LOW  = 4'h0;
   localparam logic [3:0] ADDR_FULL_HIGH = 4'h1;
   localparam logic [3:0] ADDR_OVF_LOW   = 4'h2;
   localparam logic [3:0] ADDR_OVF_HIGH  = 4'h3;
   localparam logic [3:0] ADDR_IRQ_STAT  = 4'h4;
   localparam logic [3:0] ADDR_IRQ_CLR   = 4'h5;
   localparam logic [3:0] ADDR_IRQ_EN    = 4'h6;

   localparam logic [15:0] FLAG_RESET    = 16'h0000;
   localparam logic [15:0] READ_ZERO     = 16'h0000;
   localparam logic [1:0]  IRQ_RESET     = 2'h0;

   // Interrupt status bit positions
   localparam int unsigned IRQ_STORE_BIT = 0;
   localparam int unsigned IRQ_OVF_BIT   = 1;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [REG_W-1:0]  wdata;
      logic              wr;
      logic              rd;
   } rxfb_bus_type;

endpackage : rxfb_pkg

// ---- rxfb_flag_half.sv ----
// One 16-bit half of a flag register pair: full and overflow flags of 16 buffers.
// Assumes store strobes are one-cycle pulses synchronous to clk.
`timescale 1ns/1ps
module rxfb_flag_half
   import rxfb_pkg::*;
#(
   parameter int unsigned WIDTH = REG_W
) (
   input  wire logic             clk,        // Module clock
   input  wire logic             rstn,       // Async reset, active low
   input  wire logic [WIDTH-1:0] store,      // Per-buffer store attempt
   input  wire logic             wr_full,    // Write to full-flag register
   input  wire logic             wr_ovf,     // Write to overflow register
   input  wire logic [WIDTH-1:0] wdata,      // Write data
   output logic      [WIDTH-1:0] full,       // Full flags
   output logic      [WIDTH-1:0] ovf,        // Overflow flags
   output logic      [WIDTH-1:0] ovf_event   // New overflow this cycle
);

   logic [WIDTH-1:0] next_full;
   logic [WIDTH-1:0] next_ovf;

   always_comb begin
      for (int i = 0; i < WIDTH; i++) begin
         next_full[i] = full[i];
         next_ovf[i]  = ovf[i];
         ovf_event[i] = store[i] & full[i];
         // Writing one leaves a flag as it is; zero clears
         if (wr_full && !wdata[i]) begin
            next_full[i] = 1'b0;
         end
         if (wr_ovf && !wdata[i]) begin
            next_ovf[i] = 1'b0;
         end
         // Set wins over a clear in the same cycle
         if (store[i]) begin
            next_full[i] = 1'b1;
         end
         if (ovf_event[i]) begin
            next_ovf[i] = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         full <= FLAG_RESET[WIDTH-1:0];
         ovf  <= FLAG_RESET[WIDTH-1:0];
      end else begin
         full <= next_full;
         ovf  <= next_ovf;
      end
   end

endmodule : rxfb_flag_half

// ---- rxfb_bank.sv ----
// Receive buffer flag bank: full and overflow flags for 32 receive buffers,
// register port, and one level interrupt.
// Assumes store strobes come from the receive path, one cycle per stored message.
//
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/1ps
module rxfb_bank
   import rxfb_pkg::*;
#(
   parameter int unsigned NBUF = NUM_BUF
) (
   input  wire logic              clk,       // Module clock, 125 MHz
   input  wire logic              rstn,      // Async reset, active low
   input  wire logic [NBUF-1:0]   store,     // Store attempt per buffer, one-cycle pulse
   input  wire logic [ADDR_W-1:0] addr,      // Register index
   input  wire logic [REG_W-1:0]  wdata,     // Write data
   input  wire logic              wr,        // Write strobe
   input  wire logic              rd,        // Read strobe
   output logic      [REG_W-1:0]  rdata,     // Read data, cycle after rd
   output logic      [NBUF-1:0]   full,      // Full flags to receive path
   output logic                   irq        // Level interrupt
);

   localparam int unsigned NHALF = NBUF / REG_W;

   rxfb_bus_type bus;
   logic [NBUF-1:0]  ovf;
   logic [NBUF-1:0]  ovf_event;
   logic [IRQ_W-1:0] irq_stat;
   logic [IRQ_W-1:0] irq_en;
   logic [IRQ_W-1:0] next_irq_stat;
   logic [IRQ_W-1:0] next_irq_en;
   logic [REG_W-1:0] next_rdata;

   assign bus.addr  = addr;
   assign bus.wdata = wdata;
   assign bus.wr    = wr;
   assign bus.rd    = rd;

   function automatic logic hit(input rxfb_bus_type b, input logic [ADDR_W-1:0] a);
      hit = b.wr && (b.addr == a);
   endfunction : hit

   // Low half at the low index, high half one above
   genvar g;
   generate
      for (g = 0; g < NHALF; g++) begin : g_half
         rxfb_flag_half #(
            .WIDTH (REG_W)
         ) u_half (
            .clk       (clk),
            .rstn      (rstn),
            .store     (store[g*REG_W +: REG_W]),
            .wr_full   (hit(bus, ADDR_FULL_LOW + ADDR_W'(g))),
            .wr_ovf    (hit(bus, ADDR_OVF_LOW + ADDR_W'(g))),
            .wdata     (bus.wdata),
            .full      (full[g*REG_W +: REG_W]),
            .ovf       (ovf[g*REG_W +: REG_W]),
            .ovf_event (ovf_event[g*REG_W +: REG_W])
         );
      end
   endgenerate

   // Interrupt: sticky status, set beats write-one clear
   always_comb begin
      next_irq_stat = irq_stat;
      next_irq_en   = irq_en;
      if (hit(bus, ADDR_IRQ_CLR)) begin
         next_irq_stat = irq_stat & ~bus.wdata[IRQ_W-1:0];
      end
      if (hit(bus, ADDR_IRQ_EN)) begin
         next_irq_en = bus.wdata[IRQ_W-1:0];
      end
      if (|store) begin
         next_irq_stat[IRQ_STORE_BIT] = 1'b1;
      end
      if (|ovf_event) begin
         next_irq_stat[IRQ_OVF_BIT] = 1'b1;
      end
   end

   // Read mux; unmapped indices read as zero
   always_comb begin
      next_rdata = READ_ZERO;
      if (bus.rd) begin
         unique case (bus.addr)
            ADDR_FULL_LOW:  next_rdata = full[REG_W-1:0];
            ADDR_FULL_HIGH: next_rdata = full[NBUF-1:REG_W];
            ADDR_OVF_LOW:   next_rdata = ovf[REG_W-1:0];
            ADDR_OVF_HIGH:  next_rdata = ovf[NBUF-1:REG_W];
            ADDR_IRQ_STAT:  next_rdata = {{(REG_W-IRQ_W){1'b0}}, irq_stat};
            ADDR_IRQ_EN:    next_rdata = {{(REG_W-IRQ_W){1'b0}}, irq_en};
            default:        next_rdata = READ_ZERO;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq_stat <= IRQ_RESET;
         irq_en   <= IRQ_RESET;
         rdata    <= READ_ZERO;
      end else begin
         irq_stat <= next_irq_stat;
         irq_en   <= next_irq_en;
         rdata    <= next_rdata;
      end
   end

   assign irq = |(irq_stat & irq_en);

endmodule : rxfb_bank

// ---- rxfb_monitor.sv ----
// Checker of the flag bank ports.
// Assumes binding onto rxfb_bank.
`timescale 1ns/1ps
module rxfb_monitor
   import rxfb_pkg::*;
#(parameter int unsigned NBUF = NUM_BUF) (
   input wire logic              clk,   // Clock
   input wire logic              rstn,  // Reset
   input wire logic [NBUF-1:0]   store, // Stores
   input wire logic [ADDR_W-1:0] addr,  // Index
   input wire logic              wr,    // Write
   input wire logic              rd,    // Read
   input wire logic [REG_W-1:0]  rdata, // Read data
   input wire logic [NBUF-1:0]   full   // Full flags
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   property p_set; |store |=> (full & $past(store)) == $past(store); endproperty
   a_set: assert property (p_set) else $error("store lost");
   // Software writes must never raise a full flag
   property p_nsw; 1'b1 |=> (full & ~$past(full) & ~$past(store)) == '0; endproperty
   a_nsw: assert property (p_nsw) else $error("flag rose");
   property p_flo; rd && addr == ADDR_FULL_LOW |=> rdata == $past(full[15:0]); endproperty
   a_flo: assert property (p_flo) else $error("full low");
   property p_fhi; rd && addr == ADDR_FULL_HIGH |=> rdata == $past(full[31:16]); endproperty
   a_fhi: assert property (p_fhi) else $error("full high");
   property p_olo; store[0] && full[0] ##1 rd && addr == ADDR_OVF_LOW |=> rdata[0]; endproperty
   a_olo: assert property (p_olo) else $error("ovf low");
   property p_ohi; store[16] && full[16] ##1 rd && addr == ADDR_OVF_HIGH |=> rdata[0]; endproperty
   a_ohi: assert property (p_ohi) else $error("ovf high");
   property p_rst; $rose(rstn) |-> full == '0; endproperty
   a_rst: assert property (p_rst) else $error("reset");
   c_ovf: cover property (|(store & full));
   c_wr: cover property (wr && addr == ADDR_IRQ_CLR);
   c_rd: cover property (rd && addr == ADDR_OVF_HIGH);
endmodule : rxfb_monitor
bind rxfb_bank rxfb_monitor #(.NBUF(NBUF)) u_mon (.clk(clk), .rstn(rstn), .store(store),
   .addr(addr), .wr(wr), .rd(rd), .rdata(rdata), .full(full));

// ---- tb_rxfb_bank.sv ----
// Testbench of rxfb_bank.
// Assumes the checker is bound.
`timescale 1ns/1ps
module tb_rxfb_bank
   import rxfb_pkg::*;
;
   logic clk, rstn, wr, rd, irq;
   logic [31:0] store, full;
   logic [3:0] addr;
   logic [15:0] wdata, rdata;
   int fail_count, tests_run;
   rxfb_bank DUT (.clk(clk), .rstn(rstn), .store(store), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .full(full), .irq(irq));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
      tests_run++;
      if (s !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask : wr_reg
   // Read data stands one cycle only, so sample mid-cycle
   task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk("rdata", rdata, e);
      @(posedge clk);
   endtask : rd_reg
   task automatic end_sim;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_sim
   initial begin
      #20us;
      fail_count++;
      end_sim();
   end
   initial begin
      {rstn, wr, rd, store, addr, wdata, fail_count, tests_run} = '0;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 4; i++)
         rd_reg(4'(i), 16'h0000);
      $display("reset done");
      store <= 32'h0008_0008;
      @(posedge clk);
      store <= '0;
      rd_reg(ADDR_FULL_LOW, 16'h0008);
      rd_reg(ADDR_FULL_HIGH, 16'h0008);
      wr_reg(ADDR_FULL_LOW, 16'hFFFF);
      rd_reg(ADDR_FULL_LOW, 16'h0008);
      wr_reg(ADDR_FULL_LOW, 16'hFFF7);
      rd_reg(ADDR_FULL_LOW, 16'h0000);
      $display("full done");
      for (int k = 0; k < 2; k++) begin
         store <= (k == 1) ? 32'h0001_0000 : 32'h0000_0001;
         repeat (2) @(posedge clk);
         store <= '0;
         rd_reg(ADDR_FULL_LOW + 4'(2 + k), 16'h0001);
      end
      wr_reg(ADDR_OVF_LOW, 16'hFFFE);
      rd_reg(ADDR_OVF_LOW, 16'h0000);
      $display("overflow done");
      chk("irq", 16'(irq), 16'h0000);
      wr_reg(ADDR_IRQ_EN, 16'h0003);
      chk("irq", 16'(irq), 16'h0001);
      wr_reg(ADDR_IRQ_CLR, 16'h0003);
      chk("irq", 16'(irq), 16'h0000);
      $display("irq done");
      end_sim();
   end
endmodule : tb_rxfb_bank
